// file: core/abbe_core.sv
/*
 * Execute logic for the literal AND, register AND, branch on carry and
 * bit clear instructions, with an APB register window.
 * Assumes the fetch unit offers words on the same clock, and that the
 * register file returns read data combinationally for the held address.
 */
//
// Contract
// - Literal AND: accumulator AND literal into accumulator, set N and Z.
// - Register AND: accumulator AND register, set N and Z, d=0 to accumulator.
// - Register AND with d=1 writes the result back to the register.
// - Access bit 0 selects the fixed access bank, 1 uses bank pointer.
// - Branch on carry taken only when carry is set; flags untouched.
// - Branch offset is signed -128..127, doubled before adding to PC.
// - Taken branch loads incremented PC plus twice offset, then a no-op cycle.
// - Bit clear clears bit b of the register in one cycle, flags untouched.
`timescale 1ns/1ps
module abbe_core (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Instruction from fetch
	input  wire logic                          instr_valid,
	input  wire logic [15:0]                   instr_word,
	output logic                               instr_ready,
	// Data register file
	output abbe_pkg::abbe_rf_req_s             rf_req,
	input  wire logic [7:0]                    rf_rdata
);

	abbe_pkg::abbe_state_e          state_reg;
	abbe_pkg::abbe_op_e             op_reg;
	logic [15:0]                    instr_reg;
	logic                           nop_reg;
	logic                           run_reg;
	logic [7:0]                     acc_reg;
	logic [2:0]                     flag_reg;
	logic [abbe_pkg::BANK_W-1:0]    bank_reg;
	logic [abbe_pkg::PC_W-1:0]      pc_reg;
	logic                           badop_reg;
	logic [7:0]                     operand_reg;
	logic [7:0]                     result_reg;
	logic                           taken_reg;
	abbe_pkg::abbe_op_e             op_next;
	logic [abbe_pkg::ADDR_W-1:0]    eff_addr;
	logic [abbe_pkg::PC_W-1:0]      br_offset;
	logic                           wr_en;
	logic                           rd_en;
	logic                           addr_ok;
	logic [2:0]                     bit_sel;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign bit_sel = instr_reg[11:9];
	assign addr_ok = (paddr == abbe_pkg::OFF_CTRL) ||
		(paddr == abbe_pkg::OFF_ACC) || (paddr == abbe_pkg::OFF_STATUS) ||
		(paddr == abbe_pkg::OFF_BANK) || (paddr == abbe_pkg::OFF_PC) ||
		(paddr == abbe_pkg::OFF_EXEC);
	assign pslverr = psel && penable && !addr_ok;
	assign instr_ready = (state_reg == abbe_pkg::ST_IDLE) && run_reg;

	always_comb begin
		if (instr_word[15:8] == abbe_pkg::OPC_AND_LIT) begin
			op_next = abbe_pkg::OP_AND_LIT;
		end else if (instr_word[15:10] == abbe_pkg::OPC_AND_REG) begin
			op_next = abbe_pkg::OP_AND_REG;
		end else if (instr_word[15:8] == abbe_pkg::OPC_BR_CARRY) begin
			op_next = abbe_pkg::OP_BR_CARRY;
		end else if (instr_word[15:12] == abbe_pkg::OPC_BIT_CLEAR) begin
			op_next = abbe_pkg::OP_BIT_CLEAR;
		end else begin
			op_next = abbe_pkg::OP_NONE;
		end
	end

	always_comb begin
		if (instr_reg[8]) begin
			eff_addr = {bank_reg, instr_reg[7:0]};
		end else if (instr_reg[7:0] < abbe_pkg::ACCESS_SPLIT) begin
			eff_addr = {{abbe_pkg::BANK_W{1'b0}}, instr_reg[7:0]};
		end else begin
			eff_addr = {abbe_pkg::ACCESS_HIGH, instr_reg[7:0]};
		end
	end

	assign br_offset = {{(abbe_pkg::PC_W-9){instr_reg[7]}},
		instr_reg[7:0], 1'b0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= abbe_pkg::ST_IDLE;
			nop_reg   <= 1'b0;
			op_reg    <= abbe_pkg::OP_NONE;
			instr_reg <= 16'h0000;
		end else begin
			case (state_reg)
			abbe_pkg::ST_IDLE: begin
				if (instr_valid && run_reg) begin
					instr_reg <= instr_word;
					op_reg    <= op_next;
					state_reg <= abbe_pkg::ST_DEC;
				end
			end
			abbe_pkg::ST_DEC:   state_reg <= abbe_pkg::ST_READ;
			abbe_pkg::ST_READ:  state_reg <= abbe_pkg::ST_PROC;
			abbe_pkg::ST_PROC:  state_reg <= abbe_pkg::ST_WRITE;
			abbe_pkg::ST_WRITE: begin
				if (!nop_reg && taken_reg) begin
					nop_reg   <= 1'b1;
					state_reg <= abbe_pkg::ST_DEC;
				end else begin
					nop_reg   <= 1'b0;
					state_reg <= abbe_pkg::ST_IDLE;
				end
			end
			default: state_reg <= abbe_pkg::ST_IDLE;
			endcase
		end
	end

	// Operand read and data processing.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand_reg <= 8'h00;
			result_reg  <= 8'h00;
			taken_reg   <= 1'b0;
		end else begin
			if (state_reg == abbe_pkg::ST_IDLE) begin
				taken_reg <= 1'b0;
			end
			if (state_reg == abbe_pkg::ST_READ && !nop_reg) begin
				if (op_reg == abbe_pkg::OP_AND_LIT ||
					op_reg == abbe_pkg::OP_BR_CARRY) begin
					operand_reg <= instr_reg[7:0];
				end else begin
					operand_reg <= rf_rdata;
				end
			end
			if (state_reg == abbe_pkg::ST_PROC && !nop_reg) begin
				case (op_reg)
				abbe_pkg::OP_AND_LIT: result_reg <= acc_reg & operand_reg;
				abbe_pkg::OP_AND_REG: result_reg <= acc_reg & operand_reg;
				abbe_pkg::OP_BIT_CLEAR: begin
					result_reg <= operand_reg & ~(8'h01 << bit_sel);
				end
				abbe_pkg::OP_BR_CARRY: begin
					taken_reg <= flag_reg[abbe_pkg::FLAG_C_BIT];
				end
				default: result_reg <= result_reg;
				endcase
			end
		end
	end

	// Register file request: address from Q1, write strobe during Q4.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_req <= '0;
		end else begin
			rf_req.we <= 1'b0;
			if (state_reg == abbe_pkg::ST_DEC && !nop_reg) begin
				rf_req.addr <= eff_addr;
			end
			if (state_reg == abbe_pkg::ST_PROC && !nop_reg) begin
				if ((op_reg == abbe_pkg::OP_AND_REG && instr_reg[9]) ||
					op_reg == abbe_pkg::OP_BIT_CLEAR) begin
					rf_req.we <= 1'b1;
				end
				case (op_reg)
				abbe_pkg::OP_AND_REG: rf_req.wdata <= acc_reg & operand_reg;
				abbe_pkg::OP_BIT_CLEAR: begin
					rf_req.wdata <= operand_reg & ~(8'h01 << bit_sel);
				end
				default: rf_req.wdata <= rf_req.wdata;
				endcase
			end
		end
	end

	// Accumulator and flags; the Q4 result wins over a software write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg  <= abbe_pkg::ACC_RST;
			flag_reg <= abbe_pkg::FLAG_RST;
		end else if (state_reg == abbe_pkg::ST_WRITE && !nop_reg &&
			(op_reg == abbe_pkg::OP_AND_LIT ||
			op_reg == abbe_pkg::OP_AND_REG)) begin
			if (op_reg == abbe_pkg::OP_AND_LIT || !instr_reg[9]) begin
				acc_reg <= result_reg;
			end
			flag_reg[abbe_pkg::FLAG_N_BIT] <= result_reg[7];
			flag_reg[abbe_pkg::FLAG_Z_BIT] <= (result_reg == 8'h00);
		end else if (wr_en && paddr == abbe_pkg::OFF_ACC) begin
			acc_reg <= pwdata[7:0];
		end else if (wr_en && paddr == abbe_pkg::OFF_STATUS) begin
			flag_reg <= pwdata[2:0];
		end
	end

	// Program counter: incremented in Q1, branch target loaded in Q4.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= abbe_pkg::PC_RST;
		end else if (state_reg == abbe_pkg::ST_DEC && !nop_reg) begin
			pc_reg <= pc_reg + abbe_pkg::PC_STEP;
		end else if (state_reg == abbe_pkg::ST_WRITE && !nop_reg &&
			taken_reg) begin
			pc_reg <= pc_reg + br_offset;
		end else if (wr_en && paddr == abbe_pkg::OFF_PC) begin
			pc_reg <= pwdata[abbe_pkg::PC_W-1:0];
		end
	end

	// Software control, bank pointer and the sticky bad-opcode flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg   <= abbe_pkg::RUN_RST;
			bank_reg  <= abbe_pkg::BANK_RST;
			badop_reg <= 1'b0;
		end else begin
			if (wr_en && paddr == abbe_pkg::OFF_CTRL) begin
				run_reg <= pwdata[abbe_pkg::CTRL_RUN_BIT];
			end
			if (wr_en && paddr == abbe_pkg::OFF_BANK) begin
				bank_reg <= pwdata[abbe_pkg::BANK_W-1:0];
			end
			// A new bad opcode in the clearing cycle keeps the flag set.
			if (state_reg == abbe_pkg::ST_DEC && !nop_reg &&
				op_reg == abbe_pkg::OP_NONE) begin
				badop_reg <= 1'b1;
			end else if (wr_en && paddr == abbe_pkg::OFF_EXEC &&
				pwdata[abbe_pkg::EXEC_BADOP_BIT]) begin
				badop_reg <= 1'b0;
			end
		end
	end

	// Read data is captured in the setup cycle and held for the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr)
			abbe_pkg::OFF_CTRL:   prdata <= {31'h0000_0000, run_reg};
			abbe_pkg::OFF_ACC:    prdata <= {24'h00_0000, acc_reg};
			abbe_pkg::OFF_STATUS: prdata <= {29'h0000_0000, flag_reg};
			abbe_pkg::OFF_BANK:   prdata <= {28'h000_0000, bank_reg};
			abbe_pkg::OFF_PC:     prdata <= {11'h000, pc_reg};
			abbe_pkg::OFF_EXEC: begin
				prdata <= {30'h0000_0000, badop_reg,
					state_reg != abbe_pkg::ST_IDLE};
			end
			default: prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// file: core/abbe_pkg.sv
/*
 * Shared constants and types of the and/branch/bit-clear execute block:
 * register offsets, status bit positions, opcode patterns and carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package abbe_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_ACC    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_BANK   = 8'h0C;
	localparam logic [7:0] OFF_PC     = 8'h10;
	localparam logic [7:0] OFF_EXEC   = 8'h14;

	// Field positions.
	localparam int CTRL_RUN_BIT   = 0;
	localparam int FLAG_C_BIT     = 0;
	localparam int FLAG_Z_BIT     = 1;
	localparam int FLAG_N_BIT     = 2;
	localparam int EXEC_BUSY_BIT  = 0;
	localparam int EXEC_BADOP_BIT = 1;

	// Widths and reset values.
	localparam int PC_W   = 21;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 12;
	localparam logic [7:0]        ACC_RST   = 8'h00;
	localparam logic [2:0]        FLAG_RST  = 3'h0;
	localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;
	localparam logic [PC_W-1:0]   PC_RST    = 21'h00_0000;
	localparam logic              RUN_RST   = 1'b0;

	// Program counter step of one instruction word, in bytes.
	localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;

	// Fixed access bank: low part maps to bank 0, the rest to the top bank.
	localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
	localparam logic [BANK_W-1:0] ACCESS_HIGH  = 4'hF;

	// Opcode patterns.
	localparam logic [7:0] OPC_AND_LIT   = 8'h0B;
	localparam logic [5:0] OPC_AND_REG   = 6'h05;
	localparam logic [7:0] OPC_BR_CARRY  = 8'hE2;
	localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_DEC   = 3'h1,
		ST_READ  = 3'h3,
		ST_PROC  = 3'h2,
		ST_WRITE = 3'h6
	} abbe_state_e;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_AND_LIT,
		OP_AND_REG,
		OP_BR_CARRY,
		OP_BIT_CLEAR
	} abbe_op_e;

	// Request toward the data register file.
	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} abbe_rf_req_s;

endpackage

// file: sim/abbe_monitor.sv
/* Assertion checker of the execute block, bound to abbe_core.
 * Assumes a register file that answers combinationally. */
`timescale 1ns/1ps
module abbe_monitor (
	// Clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// Instruction and register file
	input wire logic                   instr_valid,
	input wire logic [15:0]            instr_word,
	input wire logic                   instr_ready,
	input wire abbe_pkg::abbe_rf_req_s rf_req,
	input wire logic [7:0]             rf_rdata
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic        take;
	logic [11:0] low_addr;
	logic        hi;
	assign take     = instr_valid && instr_ready;
	assign hi       = instr_word[7:0] >= abbe_pkg::ACCESS_SPLIT;
	assign low_addr = {hi ? abbe_pkg::ACCESS_HIGH : 4'h0, instr_word[7:0]};
	lit_no_write_a: assert property (
		take && instr_word[15:8] == 8'h0B |=> !rf_req.we [*4])
		else $error("literal AND wrote the register file");
	and_to_acc_a: assert property (
		take && instr_word[15:9] == 7'h0A |=> !rf_req.we [*4])
		else $error("register AND to accumulator wrote a register");
	and_writeback_a: assert property (
		take && instr_word[15:9] == 7'h0B |-> ##4 rf_req.we)
		else $error("register AND write-back missing");
	access_bank_a: assert property (
		rf_req.we && !$past(instr_word[8], 4) |->
			rf_req.addr == $past(low_addr, 4))
		else $error("access bank address wrong");
	branch_no_write_a: assert property (
		take && instr_word[15:8] == 8'hE2 |=> !rf_req.we [*4])
		else $error("branch wrote the register file");
	branch_length_a: assert property (
		take && instr_word[15:8] == 8'hE2 |=> !instr_ready [*4] ##1
			(instr_ready or (!instr_ready [*4] ##1 instr_ready)))
		else $error("branch length wrong");
	bit_clear_a: assert property (
		take && instr_word[15:12] == 4'h9 |-> ##4 rf_req.we &&
			rf_req.wdata == (rf_rdata & ~(8'h01 << $past(instr_word[11:9], 4))))
		else $error("bit clear data wrong");
	write_phase_a: assert property (
		rf_req.we |-> $past(take, 4))
		else $error("register write outside the fourth phase");
endmodule

bind abbe_core abbe_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.instr_valid(instr_valid), .instr_word(instr_word),
	.instr_ready(instr_ready), .rf_req(rf_req), .rf_rdata(rf_rdata));

// file: sim/test_and_branch_bitclear_execute.sv
/* Self-checking bench of the execute block: APB master, register file
 * model and instruction driver. Assumes the core and package in core/. */
`timescale 1ns/1ps
module test_and_branch_bitclear_execute;
	logic                   pclk, presetn, psel, penable, pwrite;
	logic [7:0]             paddr, rf_rdata, acc, f, r, m;
	logic [31:0]            pwdata, prdata, q;
	logic                   pready, pslverr, instr_valid, instr_ready, e;
	logic [15:0]            instr_word, w;
	abbe_pkg::abbe_rf_req_s rf_req;
	logic [7:0]             rf_mem [0:4095];
	logic [2:0]             st;
	logic [3:0]             bk;
	logic [20:0]            pc, pce;
	logic [11:0]            ad;
	int                     err_count, checked;
	logic [15:0]            corner [0:5] = '{16'hE280, 16'hE27F, 16'h1701,
		16'h1480, 16'h9E7F, 16'h0B00};

	abbe_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .rf_req(rf_req), .rf_rdata(rf_rdata));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	assign rf_rdata = rf_mem[rf_req.addr];
	always @(posedge pclk) begin
		if (rf_req.we === 1'b1)
			rf_mem[rf_req.addr] <= rf_req.wdata;
	end

	task automatic chk(input string n, input logic [31:0] x, g);
		checked++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Selects the handshake to wait on, so no reference argument is needed.
	task automatic wait_hi(input bit on_instr);
		int   n;
		logic s;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			s = on_instr ? instr_ready : pready;
		end while (s !== 1'b1 && n < 30);
		if (s !== 1'b1) begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wait_hi(1'b0);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [15:0] wd);
		@(posedge pclk);
		instr_valid <= 1'b1;
		instr_word  <= wd;
		wait_hi(1'b1);
		instr_valid <= 1'b0;
		wait_hi(1'b1);
	endtask
	// Expected program counter: one word step, plus twice the signed offset
	// when a branch on carry is taken.
	function automatic logic [20:0] exp_pc(input logic [20:0] p,
		input logic [15:0] wd, input logic c);
		logic [20:0] t;
		t = p + 21'h00_0002;
		if (wd[15:8] == 8'hE2 && c)
			t = t + {{12{wd[7]}}, wd[7:0], 1'b0};
		return t;
	endfunction

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{instr_valid, instr_word, presetn} = '0;
		err_count = 0;
		checked = 0;
		void'($urandom(32'haeed_8e05));
		for (int i = 0; i < 4096; i++)
			rf_mem[i] = 8'($urandom);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 24; a += 4) begin
			apb(1'b0, 8'(a), 32'h0000_0000);
			chk("reset value", 32'h0000_0000, q);
		end
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, e});
		chk("unmapped data", 32'h0000_0000, q);
		apb(1'b1, 8'h18, 32'h0000_00FF);
		chk("unmapped write error", 32'h0000_0001, {31'h0, e});
		apb(1'b1, abbe_pkg::OFF_CTRL, 32'h0000_0001);
		for (int i = 0; i < 60; i++) begin
			acc = 8'($urandom);
			st  = 3'($urandom);
			bk  = 4'($urandom);
			pc  = 21'($urandom) & 21'h1F_FFFE;
			if (i < 2)
				st[0] = 1'b1;
			if (i < 6)
				w = corner[i];
			else case ($urandom % 4)
				0: w = {8'h0B, 8'($urandom)};
				1: w = {6'h05, 10'($urandom)};
				2: w = {8'hE2, 8'($urandom)};
				default: w = {4'h9, 12'($urandom)};
			endcase
			apb(1'b1, abbe_pkg::OFF_ACC, {24'h0, acc});
			apb(1'b1, abbe_pkg::OFF_STATUS, {29'h0, st});
			apb(1'b1, abbe_pkg::OFF_BANK, {28'h0, bk});
			apb(1'b1, abbe_pkg::OFF_PC, {11'h0, pc});
			f   = w[7:0];
			ad  = w[8] ? {bk, f} : {f[7] ? 4'hF : 4'h0, f};
			m   = rf_mem[ad];
			pce = exp_pc(pc, w, st[0]);
			run(w);
			if (w[15:8] == 8'h0B || w[15:10] == 6'h05) begin
				r = acc & (w[15:8] == 8'h0B ? f : m);
				st[2:1] = {r[7], r == 8'h00};
				if (w[15:9] == 7'h0B)
					m = r;
				else
					acc = r;
			end
			if (w[15:12] == 4'h9)
				m[w[11:9]] = 1'b0;
			apb(1'b0, abbe_pkg::OFF_ACC, 32'h0000_0000);
			chk("accumulator", {24'h0, acc}, q);
			apb(1'b0, abbe_pkg::OFF_STATUS, 32'h0000_0000);
			chk("status", {29'h0, st}, q);
			apb(1'b0, abbe_pkg::OFF_PC, 32'h0000_0000);
			chk("program counter", {11'h0, pce}, q);
			chk("register file", {24'h0, m}, {24'h0, rf_mem[ad]});
		end
		// An unknown opcode runs the four phases, leaves the accumulator and
		// sets the sticky flag, which a write of one clears.
		run(16'hFFFF);
		apb(1'b0, abbe_pkg::OFF_ACC, 32'h0000_0000);
		chk("accumulator kept", {24'h0, acc}, q);
		apb(1'b0, abbe_pkg::OFF_EXEC, 32'h0000_0000);
		chk("bad opcode flag", 32'h0000_0002, q);
		apb(1'b1, abbe_pkg::OFF_EXEC, 32'h0000_0002);
		apb(1'b0, abbe_pkg::OFF_EXEC, 32'h0000_0000);
		chk("bad opcode clear", 32'h0000_0000, q);
		tally_and_finish();
	end
endmodule
